// File: verilog/pmc_pkg.sv
// shared constants and carrier types of the power module configuration registers
package pmc_pkg;
  // command codes of the configuration registers
  localparam logic [7:0]  CODE_LEGACY_MASK = 8'ha8;
  localparam logic [7:0]  CODE_USER_TEXT   = 8'hb0;
  localparam logic [7:0]  CODE_CS_SETUP    = 8'hd0;
  localparam logic [7:0]  CODE_UF_SETUP    = 8'hd1;
  localparam logic [7:0]  CODE_RAIL_SETUP  = 8'hd3;
  localparam logic [7:0]  CODE_OK_DELAY    = 8'hd4;

  // reset values
  localparam logic [31:0] RST_LEGACY_MASK  = 32'h0000_0000;
  localparam logic [7:0]  RST_CS_SETUP     = 8'h05;
  localparam logic [7:0]  RST_UF_SETUP     = 8'h00;
  localparam logic [7:0]  RST_RAIL_SETUP   = 8'h00;
  localparam logic [15:0] RST_OK_DELAY     = 16'hca00;

  // writable field masks, reserved bits cleared
  localparam logic [7:0]  CS_MASK          = 8'h0f;
  localparam logic [7:0]  UF_MASK          = 8'h1f;
  localparam logic [7:0]  RAIL_MASK        = 8'h1f;

  // field positions
  localparam int          CS_BLANK_LSB     = 2;
  localparam int          CS_RANGE_LSB     = 0;
  localparam logic [1:0]  CS_RANGE_UNUSED  = 2'h3;
  localparam int          UF_RAMP_LSB      = 3;
  localparam int          UF_MINDUTY_BIT   = 2;
  localparam int          UF_PUSHPULL_BIT  = 1;
  localparam int          UF_EXTERNAL_TEMP_INPUT_BIT     = 0;
  localparam int          LEGACY_RAIL_NUMBER_LSB      = 0;
  localparam int          GFS_IMMEDIATE_BIT = 5;
  localparam int          GFS_GROUP_LSB    = 0;
  localparam int          L11_EXP_LSB      = 11;

  // text store sizing
  localparam logic [8:0]  TEXT_LIMIT       = 9'h080;
  localparam int          TEXT_DEPTH       = 128;
  localparam int          TEXT_AW          = 7;

  // timing
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          OK_STEP_NS       = 125;
  localparam int          OK_MAX_S         = 500;
  localparam logic [7:0]  OK_PHASE_INC     = 8'(CLK_PERIOD_NS);
  localparam logic [7:0]  OK_PHASE_WRAP    = 8'(OK_STEP_NS);
  localparam logic [39:0] OK_TICKS_PER_MS  = 40'(1000000 / OK_STEP_NS);
  localparam logic [39:0] OK_MAX_TICKS     = 40'(OK_MAX_S) * 40'(1000000000 / OK_STEP_NS);
  localparam logic [1:0]  STRAP_SETTLE     = 2'h2;

  typedef enum logic [1:0] {
    PMC_OK_IDLE = 2'b00,
    PMC_OK_WAIT = 2'b01,
    PMC_OK_ON   = 2'b10
  } pmc_ok_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        first;
    logic [7:0]  code;
    logic [31:0] wdata;
  } pmc_req_t;

  typedef struct packed {
    logic        rvalid;
    logic        refused;
    logic [31:0] rdata;
  } pmc_rsp_t;

  typedef struct packed {
    logic        event_valid;
    logic        legacy;
    logic [4:0]  number;
  } pmc_fault_t;
endpackage : pmc_pkg

// File: verilog/pmc_text_mem.sv
// byte memory of the user text store with registered read data
`timescale 1ns/10ps
module pmc_text_mem (
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       wr_en,
  input  wire logic [pmc_pkg::TEXT_AW-1:0] wr_addr,
  input  wire logic [7:0]                 wr_data,
  input  wire logic                       rd_en,
  input  wire logic [pmc_pkg::TEXT_AW-1:0] rd_addr,
  output logic      [7:0]                 rd_data
);
  typedef struct packed {
    logic [7:0] rd_data;
  } pmc_mem_state_t;

  logic [7:0]     mem [pmc_pkg::TEXT_DEPTH];
  pmc_mem_state_t st_q;
  pmc_mem_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (rd_en) begin
      st_d.rd_data = mem[rd_addr];
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd_data;
endmodule // pmc_text_mem

// File: verilog/pmc_config_regs.sv
// configuration register bank of the power module controller
//
// Behaviour
// - 32-bit mask, one listen bit per legacy rail
// - shut down on selected group fault, or on masked legacy rail fault only when immediate bit set
// - mask reads and writes whole, resets zero
// - text plus command bytes limited to 128
// - bits 3:2 select current-sense blanking time
// - bits 1:0 select sense range, 11 unused
// - written feature setup overrides pin strap
// - bits 4:3 pick ramp minimum duty cycle
// - bit 2 enables minimum duty cycle control
// - bit 1 selects output-ok push-pull drive
// - bit 0 enables external temperature monitoring
// - bits 4:0 hold inter-module bus rail address
// - wait programmed delay before asserting output-ok
// - delay counts in 125ns steps, capped 500s
// - delay is linear-11 ms, resets to 4ms
// - immediate bit picks immediate or sequenced shutdown
`timescale 1ns/10ps
module pmc_config_regs (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire pmc_pkg::pmc_req_t  req,
  output pmc_pkg::pmc_rsp_t       rsp,
  input  wire logic [7:0]         maker_text_len,
  input  wire logic               nvm_store,
  input  wire logic               nvm_restore,
  input  wire logic [7:0]         group_fault_setup,
  input  wire pmc_pkg::pmc_fault_t fault_bcast,
  input  wire logic [7:0]         config_strap,
  input  wire logic               vout_above_thr,
  output logic                    shutdown_immediate,
  output logic                    shutdown_sequenced,
  output logic [1:0]              cs_blank_code,
  output logic [1:0]              cs_range_code,
  output logic [1:0]              ramp_min_duty_code,
  output logic                    min_duty_en,
  output logic                    ext_temp_en,
  output logic [4:0]              inter_module_bus_legacy_rail_number,
  output logic                    output_ok_pin_o,
  output logic                    output_ok_pin_oe,
  output logic                    output_ok
);
  typedef struct packed {
    logic [31:0]            legacy_mask;
    logic [7:0]             cs;
    logic [7:0]             uf;
    logic                   uf_written;
    logic [7:0]             strap_s1;
    logic [7:0]             strap_s2;
    logic [7:0]             strap;
    logic [1:0]             strap_cnt;
    logic [7:0]             rail;
    logic [15:0]            okd;
    logic [8:0]             used;
    logic [8:0]             committed;
    logic [7:0]             text_len;
    logic [6:0]             rd_ptr;
    pmc_pkg::pmc_ok_state_t ok_st;
    logic [7:0]             phase;
    logic [31:0]            ticks;
    logic                   ok;
    logic                   pin_o;
    logic                   pin_oe;
    logic [31:0]            rdata;
    logic                   rvalid;
    logic                   refused;
    logic                   sel_text;
    logic                   sd_imm;
    logic                   sd_seq;
  } pmc_state_t;

  pmc_state_t st_q;
  pmc_state_t st_d;

  logic                        mem_wr;
  logic [pmc_pkg::TEXT_AW-1:0] mem_waddr;
  logic                        mem_rd;
  logic [pmc_pkg::TEXT_AW-1:0] mem_raddr;
  logic [7:0]                  mem_rdata;
  logic [7:0]                  uf_eff;
  logic [31:0]                 ok_target;

  // converts a linear-11 millisecond value into 125ns steps
  function automatic logic [31:0] l11_to_ticks(input logic [15:0] v);
    logic signed [4:0] e;
    logic [10:0]       m;
    logic [39:0]       base;
    logic [39:0]       t;
    e    = v[15:pmc_pkg::L11_EXP_LSB];
    m    = v[pmc_pkg::L11_EXP_LSB-1:0];
    base = 40'(m) * pmc_pkg::OK_TICKS_PER_MS;
    if (m[10]) begin
      t = '0;
    end else if (e[4]) begin
      t = base >> 5'(~e + 5'sd1);
    end else begin
      t = base << 5'(e);
    end
    if (t > pmc_pkg::OK_MAX_TICKS) begin
      t = pmc_pkg::OK_MAX_TICKS;
    end
    return t[31:0];
  endfunction

  // feature setup seen by the converter, strap until software writes it
  function automatic logic [7:0] feature_value(input logic written, input logic [7:0] reg_v,
                                               input logic [7:0] strap_v);
    return written ? reg_v : (strap_v & pmc_pkg::UF_MASK);
  endfunction

  assign uf_eff    = feature_value(st_q.uf_written, st_q.uf, st_q.strap);
  assign ok_target = l11_to_ticks(st_q.okd);

  always_comb begin
    logic [8:0] need;
    logic [8:0] total;
    logic       fits;
    logic       g_hit;
    logic       l_hit;
    need      = 9'h000;
    total     = 9'h000;
    fits      = 1'b0;
    g_hit     = 1'b0;
    l_hit     = 1'b0;
    st_d      = st_q;
    mem_wr    = 1'b0;
    mem_waddr = st_q.text_len[pmc_pkg::TEXT_AW-1:0];
    mem_rd    = 1'b0;
    mem_raddr = st_q.rd_ptr;

    st_d.rvalid   = 1'b0;
    st_d.refused  = 1'b0;
    st_d.sel_text = 1'b0;
    st_d.sd_imm   = 1'b0;
    st_d.sd_seq   = 1'b0;

    // strap pins pass two flops, then are caught once the second flop holds the pin
    st_d.strap_s1 = config_strap;
    st_d.strap_s2 = st_q.strap_s1;
    if (st_q.strap_cnt != pmc_pkg::STRAP_SETTLE + 2'h1) begin
      st_d.strap_cnt = st_q.strap_cnt + 2'h1;
    end
    if (st_q.strap_cnt == pmc_pkg::STRAP_SETTLE) begin
      st_d.strap = st_q.strap_s2;
    end

    // register writes and reads
    if (req.valid && req.write) begin
      case (req.code)
        pmc_pkg::CODE_LEGACY_MASK: begin
          st_d.legacy_mask = req.wdata;
        end
        pmc_pkg::CODE_CS_SETUP: begin
          if (req.wdata[pmc_pkg::CS_RANGE_LSB +: 2] == pmc_pkg::CS_RANGE_UNUSED) begin
            st_d.refused = 1'b1;
          end else begin
            st_d.cs = req.wdata[7:0] & pmc_pkg::CS_MASK;
          end
        end
        pmc_pkg::CODE_UF_SETUP: begin
          st_d.uf         = req.wdata[7:0] & pmc_pkg::UF_MASK;
          st_d.uf_written = 1'b1;
        end
        pmc_pkg::CODE_RAIL_SETUP: begin
          st_d.rail = req.wdata[7:0] & pmc_pkg::RAIL_MASK;
        end
        pmc_pkg::CODE_OK_DELAY: begin
          st_d.okd = req.wdata[15:0];
        end
        pmc_pkg::CODE_USER_TEXT: begin
          need  = req.first ? 9'h002 : 9'h001;
          total = 9'(maker_text_len) + st_q.used + need;
          fits  = (total <= pmc_pkg::TEXT_LIMIT);
          if (fits) begin
            mem_wr    = 1'b1;
            mem_waddr = req.first ? '0 : st_q.text_len[pmc_pkg::TEXT_AW-1:0];
            st_d.text_len = req.first ? 8'h01 : st_q.text_len + 8'h01;
            st_d.used     = st_q.used + need;
          end else begin
            st_d.refused = 1'b1;
          end
        end
        default: begin
          st_d.refused = 1'b1;
        end
      endcase
    end else if (req.valid) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = 32'h0000_0000;
      case (req.code)
        pmc_pkg::CODE_LEGACY_MASK: begin
          st_d.rdata = st_q.legacy_mask;
        end
        pmc_pkg::CODE_CS_SETUP: begin
          st_d.rdata = {24'h00_0000, st_q.cs};
        end
        pmc_pkg::CODE_UF_SETUP: begin
          st_d.rdata = {24'h00_0000, uf_eff};
        end
        pmc_pkg::CODE_RAIL_SETUP: begin
          st_d.rdata = {24'h00_0000, st_q.rail};
        end
        pmc_pkg::CODE_OK_DELAY: begin
          st_d.rdata = {16'h0000, st_q.okd};
        end
        pmc_pkg::CODE_USER_TEXT: begin
          mem_rd        = 1'b1;
          mem_raddr     = req.first ? '0 : st_q.rd_ptr;
          st_d.rd_ptr   = mem_raddr + 7'h01;
          st_d.sel_text = 1'b1;
        end
        default: begin
          st_d.rvalid  = 1'b0;
          st_d.refused = 1'b1;
        end
      endcase
    end

    // commit and reload of the text byte count
    if (nvm_store) begin
      st_d.committed = st_d.used;
    end
    if (nvm_restore) begin
      st_d.used = st_q.committed;
    end

    // fault broadcasts from the inter-module bus
    g_hit = fault_bcast.event_valid && !fault_bcast.legacy &&
            (fault_bcast.number == group_fault_setup[pmc_pkg::GFS_GROUP_LSB +: 5]);
    l_hit = fault_bcast.event_valid && fault_bcast.legacy &&
            st_q.legacy_mask[fault_bcast.number];
    if (group_fault_setup[pmc_pkg::GFS_IMMEDIATE_BIT]) begin
      st_d.sd_imm = g_hit || l_hit;
    end else begin
      st_d.sd_seq = g_hit;
    end

    // output-ok delay, 125ns steps from a 100ns clock by phase accumulation
    case (st_q.ok_st)
      pmc_pkg::PMC_OK_IDLE: begin
        st_d.ok    = 1'b0;
        st_d.phase = 8'h00;
        st_d.ticks = 32'h0000_0000;
        if (vout_above_thr) begin
          st_d.ok_st = pmc_pkg::PMC_OK_WAIT;
        end
      end
      pmc_pkg::PMC_OK_WAIT: begin
        if (!vout_above_thr) begin
          st_d.ok_st = pmc_pkg::PMC_OK_IDLE;
        end else if (st_q.ticks >= ok_target) begin
          st_d.ok_st = pmc_pkg::PMC_OK_ON;
          st_d.ok    = 1'b1;
        end else if (st_q.phase + pmc_pkg::OK_PHASE_INC >= pmc_pkg::OK_PHASE_WRAP) begin
          st_d.phase = st_q.phase + pmc_pkg::OK_PHASE_INC - pmc_pkg::OK_PHASE_WRAP;
          st_d.ticks = st_q.ticks + 32'h0000_0001;
        end else begin
          st_d.phase = st_q.phase + pmc_pkg::OK_PHASE_INC;
        end
      end
      pmc_pkg::PMC_OK_ON: begin
        if (!vout_above_thr) begin
          st_d.ok_st = pmc_pkg::PMC_OK_IDLE;
          st_d.ok    = 1'b0;
        end
      end
      default: begin
        st_d.ok_st = pmc_pkg::PMC_OK_IDLE;
        st_d.ok    = 1'b0;
      end
    endcase

    // output-ok pin drive, open drain pulls low only while not ok
    if (uf_eff[pmc_pkg::UF_PUSHPULL_BIT]) begin
      st_d.pin_oe = 1'b1;
      st_d.pin_o  = st_d.ok;
    end else begin
      st_d.pin_oe = !st_d.ok;
      st_d.pin_o  = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q             <= '0;
      st_q.legacy_mask <= pmc_pkg::RST_LEGACY_MASK;
      st_q.cs          <= pmc_pkg::RST_CS_SETUP;
      st_q.uf          <= pmc_pkg::RST_UF_SETUP;
      st_q.rail        <= pmc_pkg::RST_RAIL_SETUP;
      st_q.okd         <= pmc_pkg::RST_OK_DELAY;
      st_q.ok_st       <= pmc_pkg::PMC_OK_IDLE;
      st_q.pin_oe      <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  pmc_text_mem u_text_mem (
    .mclk    (mclk),
    .reset_n (reset_n),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (req.wdata[7:0]),
    .rd_en   (mem_rd),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  assign rsp.rvalid  = st_q.rvalid;
  assign rsp.refused = st_q.refused;
  assign rsp.rdata   = st_q.sel_text ? {24'h00_0000, mem_rdata} : st_q.rdata;

  assign shutdown_immediate       = st_q.sd_imm;
  assign shutdown_sequenced       = st_q.sd_seq;
  assign cs_blank_code            = st_q.cs[pmc_pkg::CS_BLANK_LSB +: 2];
  assign cs_range_code            = st_q.cs[pmc_pkg::CS_RANGE_LSB +: 2];
  assign ramp_min_duty_code       = uf_eff[pmc_pkg::UF_RAMP_LSB +: 2];
  assign min_duty_en              = uf_eff[pmc_pkg::UF_MINDUTY_BIT];
  assign ext_temp_en              = uf_eff[pmc_pkg::UF_EXTERNAL_TEMP_INPUT_BIT];
  assign inter_module_bus_legacy_rail_number = st_q.rail[pmc_pkg::LEGACY_RAIL_NUMBER_LSB +: 5];
  assign output_ok_pin_o          = st_q.pin_o;
  assign output_ok_pin_oe         = st_q.pin_oe;
  assign output_ok                = st_q.ok;
endmodule // pmc_config_regs

// File: verification/pmc_peer_model.sv
// peer rail model that broadcasts one fault event after a chosen wait
`timescale 1ns/10ps
module pmc_peer_model (
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          go,
  input  wire logic          legacy,
  input  wire logic [4:0]    number,
  input  wire logic [3:0]    wait_cyc,
  output pmc_pkg::pmc_fault_t fault_bcast
);
  logic [3:0] cnt_q;
  logic       busy_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      fault_bcast <= '0;
    end else begin
      // idle number and kind lines churn so only the strobe qualifies them
      fault_bcast.event_valid <= 1'b0;
      fault_bcast.number <= ~fault_bcast.number;
      fault_bcast.legacy <= ~fault_bcast.legacy;
      if (go) begin
        busy_q <= 1'b1;
        cnt_q <= wait_cyc;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        fault_bcast <= '{1'b1, legacy, number};
      end
    end
  end
endmodule // pmc_peer_model

// File: verification/pmc_config_regs_checker.sv
// concurrent checks on the configuration register bank ports
`timescale 1ns/10ps
module pmc_config_regs_checker (
  input wire logic                mclk,
  input wire logic                reset_n,
  input wire pmc_pkg::pmc_req_t   req,
  input wire pmc_pkg::pmc_rsp_t   rsp,
  input wire logic [7:0]          group_fault_setup,
  input wire pmc_pkg::pmc_fault_t fault_bcast,
  input wire logic                vout_above_thr,
  input wire logic                shutdown_immediate,
  input wire logic                shutdown_sequenced,
  input wire logic [1:0]          cs_blank_code,
  input wire logic [1:0]          cs_range_code,
  input wire logic [4:0]          inter_module_bus_legacy_rail_number,
  input wire logic                output_ok_pin_o,
  input wire logic                output_ok_pin_oe,
  input wire logic                output_ok
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  logic mapped;
  logic wr;
  logic hit;
  assign mapped = req.code inside {8'ha8, 8'hb0, 8'hd0, 8'hd1, 8'hd3, 8'hd4};
  assign wr = req.valid && req.write;
  assign hit = fault_bcast.event_valid && !fault_bcast.legacy
               && fault_bcast.number == group_fault_setup[4:0];
  a_unmapped_refused: assert property (
    req.valid && !mapped |=> rsp.refused && !rsp.rvalid) else $error("unmapped not refused");
  a_read_answered: assert property (
    req.valid && !req.write && mapped |=> rsp.rvalid && !rsp.refused) else $error("read lost");
  a_range_refused: assert property (
    wr && req.code == 8'hd0 && req.wdata[1:0] == 2'h3
    |=> rsp.refused && $stable(cs_range_code)) else $error("unused range taken");
  a_sense_update: assert property (
    wr && req.code == 8'hd0 && req.wdata[1:0] != 2'h3
    |=> {cs_blank_code, cs_range_code} == $past(req.wdata[3:0])) else $error("sense codes");
  a_rail_update: assert property (
    wr && req.code == 8'hd3 |=> inter_module_bus_legacy_rail_number == $past(req.wdata[4:0]))
    else $error("legacy_rail_number not loaded");
  a_rail_hold: assert property (
    !(wr && req.code == 8'hd3) |=> $stable(inter_module_bus_legacy_rail_number)) else $error("legacy_rail_number moved");
  a_group_response: assert property (
    hit |=> shutdown_immediate == $past(group_fault_setup[5])
    && shutdown_sequenced == !$past(group_fault_setup[5])) else $error("group response");
  a_legacy_gated: assert property (
    fault_bcast.event_valid && fault_bcast.legacy && !group_fault_setup[5]
    |=> !shutdown_immediate && !shutdown_sequenced) else $error("legacy not gated");
  a_no_spurious: assert property (
    !fault_bcast.event_valid |=> !shutdown_immediate && !shutdown_sequenced)
    else $error("shutdown without event");
  a_ok_settle: assert property (
    $rose(vout_above_thr) |=> !output_ok) else $error("ok without delay");
  a_ok_drop: assert property (
    !vout_above_thr |=> !output_ok) else $error("ok held after drop");
  a_pin_idle: assert property (
    !output_ok |-> output_ok_pin_oe && !output_ok_pin_o) else $error("pin not low");
  c_refused: cover property (rsp.refused);
  c_immediate: cover property (shutdown_immediate);
  c_sequenced: cover property (shutdown_sequenced);
  c_ok_on: cover property ($rose(output_ok));
endmodule // pmc_config_regs_checker
bind pmc_config_regs pmc_config_regs_checker u_chk (
  .mclk, .reset_n, .req, .rsp, .group_fault_setup, .fault_bcast, .vout_above_thr,
  .shutdown_immediate, .shutdown_sequenced, .cs_blank_code, .cs_range_code,
  .inter_module_bus_legacy_rail_number, .output_ok_pin_o, .output_ok_pin_oe, .output_ok);

// File: verification/pmc_config_regs_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/10ps
module pmc_config_regs_tb;
  logic                mclk;
  logic                reset_n;
  pmc_pkg::pmc_req_t   req;
  pmc_pkg::pmc_rsp_t   rsp;
  pmc_pkg::pmc_fault_t fault_bcast;
  logic [7:0]          maker_text_len, group_fault_setup, config_strap;
  logic                nvm_store, nvm_restore, vout_above_thr, go, pl;
  logic                sd_imm, sd_seq, ok, pin_o, pin_oe, min_en, xt_en;
  logic [1:0]          blank, range, ramp;
  logic [4:0]          rail, pn;
  logic [3:0]          pw;
  logic [31:0]         v, cs;
  int                  fail_count, num_checks;
  pmc_config_regs u_dut (
    .mclk, .reset_n, .req, .rsp, .maker_text_len, .nvm_store, .nvm_restore,
    .group_fault_setup, .fault_bcast, .config_strap, .vout_above_thr,
    .shutdown_immediate(sd_imm), .shutdown_sequenced(sd_seq), .cs_blank_code(blank),
    .cs_range_code(range), .ramp_min_duty_code(ramp), .min_duty_en(min_en),
    .ext_temp_en(xt_en), .inter_module_bus_legacy_rail_number(rail), .output_ok_pin_o(pin_o),
    .output_ok_pin_oe(pin_oe), .output_ok(ok));
  pmc_peer_model u_peer (
    .mclk, .reset_n, .go, .legacy(pl), .number(pn), .wait_cyc(pw), .fault_bcast);
  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask
  task automatic acc(input logic w, input logic f, input logic [7:0] c, input logic [31:0] d);
    cyc(1);
    req = '{1'b1, w, f, c, d};
    cyc(1);
    req.valid = 1'b0;
  endtask
  task automatic wr(input logic [7:0] c, input logic f, input logic [31:0] d, input logic e);
    acc(1'b1, f, c, d);
    chk(34'(rsp.refused), 34'(e));
  endtask
  task automatic rd(input logic [7:0] c, input logic f, input logic [31:0] e);
    acc(1'b0, f, c, 32'h0);
    chk({rsp.refused, rsp.rvalid, rsp.rdata}, {2'b01, e});
  endtask
  task automatic flt(input logic l, input logic [4:0] n, input logic [1:0] e);
    logic [1:0] seen;
    seen = 2'h0;
    cyc(1);
    pl = l;
    pn = n;
    pw = 4'($urandom_range(9));
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (int i = 0; i < 20; i++) begin
      cyc(1);
      seen = seen | {sd_imm, sd_seq};
    end
    chk(34'(seen), 34'(e));
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #4000000;
    fail_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'h9cba));
    {reset_n, nvm_store, nvm_restore, vout_above_thr, go, pl, pn, pw} = '0;
    req = '0;
    maker_text_len = 8'h00;
    group_fault_setup = 8'h00;
    config_strap = 8'($urandom);
    repeat (4) @(posedge mclk);
    #10;
    reset_n = 1'b1;
    cyc(3);
    rd(8'ha8, 1'b0, 32'h0);
    rd(8'hd0, 1'b0, 32'h5);
    rd(8'hd3, 1'b0, 32'h0);
    rd(8'hd4, 1'b0, 32'hca00);
    rd(8'hd1, 1'b0, 32'(config_strap & 8'h1f));
    chk(34'({blank, range}), 34'h5);
    acc(1'b0, 1'b0, 8'hff, 32'h0);
    chk(34'({rsp.refused, rsp.rvalid}), 34'h2);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(8'ha8, 1'b0, v, 1'b0);
      rd(8'ha8, 1'b0, v);
    end
    cs = 32'h5;
    for (int i = 0; i < 16; i++) begin
      v = 32'({4'($urandom), 4'(i)});
      wr(8'hd0, 1'b0, v, v[1:0] == 2'h3);
      if (v[1:0] != 2'h3) cs = {28'h0, v[3:0]};
      rd(8'hd0, 1'b0, cs);
      chk(34'({blank, range}), 34'(cs));
    end
    $display("test sense and mask done");
    for (int i = 0; i < 6; i++) begin
      v = 32'(8'($urandom));
      wr(8'hd1, 1'b0, v, 1'b0);
      config_strap = 8'($urandom);
      cyc(4);
      rd(8'hd1, 1'b0, v & 32'h1f);
      chk(34'({ramp, min_en, xt_en}), 34'({v[4:2], v[0]}));
    end
    for (int i = 0; i < 4; i++) begin
      v = 32'(8'($urandom));
      wr(8'hd3, 1'b0, v, 1'b0);
      rd(8'hd3, 1'b0, v & 32'h1f);
      chk(34'(rail), 34'(v[4:0]));
    end
    $display("test features done");
    wr(8'ha8, 1'b0, 32'h0000_0400, 1'b0);
    group_fault_setup = 8'h27;
    flt(1'b0, 5'd7, 2'h2);
    flt(1'b1, 5'd10, 2'h2);
    flt(1'b1, 5'd11, 2'h0);
    flt(1'b0, 5'd8, 2'h0);
    group_fault_setup = 8'h07;
    flt(1'b0, 5'd7, 2'h1);
    flt(1'b1, 5'd10, 2'h0);
    $display("test faults done");
    maker_text_len = 8'd120;
    wr(8'hb0, 1'b1, 32'h41, 1'b0);
    for (int i = 0; i < 6; i++) wr(8'hb0, 1'b0, 32'($urandom_range(126, 32)), 1'b0);
    wr(8'hb0, 1'b0, 32'h42, 1'b1);
    wr(8'hb0, 1'b1, 32'h43, 1'b1);
    nvm_restore = 1'b1;
    cyc(1);
    nvm_restore = 1'b0;
    wr(8'hb0, 1'b1, 32'h5a, 1'b0);
    nvm_store = 1'b1;
    cyc(1);
    nvm_store = 1'b0;
    rd(8'hb0, 1'b1, 32'h5a);
    $display("test text done");
    wr(8'hd1, 1'b0, 32'h2, 1'b0);
    wr(8'hd4, 1'b0, 32'h8001, 1'b0);
    vout_above_thr = 1'b1;
    cyc(4);
    chk(34'({ok, pin_oe, pin_o}), 34'h7);
    vout_above_thr = 1'b0;
    cyc(2);
    chk(34'(ok), 34'h0);
    wr(8'hd4, 1'b0, 32'h0001, 1'b0);
    rd(8'hd4, 1'b0, 32'h0001);
    vout_above_thr = 1'b1;
    cyc(9990);
    chk(34'(ok), 34'h0);
    cyc(30);
    chk(34'(ok), 34'h1);
    wr(8'hd1, 1'b0, 32'h0, 1'b0);
    cyc(2);
    chk(34'({ok, pin_oe, pin_o}), 34'h4);
    vout_above_thr = 1'b0;
    cyc(2);
    chk(34'({ok, pin_oe, pin_o}), 34'h2);
    $display("test output ok done");
    reset_n = 1'b0;
    cyc(1);
    reset_n = 1'b1;
    cyc(3);
    rd(8'ha8, 1'b0, 32'h0);
    rd(8'hd4, 1'b0, 32'hca00);
    rd(8'hd1, 1'b0, 32'(config_strap & 8'h1f));
    $display("test mid reset done");
    summarize();
  end
endmodule // pmc_config_regs_tb
